// *** logic/acc_top.sv ***
// converter control: registers, result lock, triggering, sequencing
//
// The register addresses and the Avalon-MM slave port were decided locally.
`timescale 1ns/1ps
module acc_top
    import acc_pkg::*;
(
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        reset_n,
    // avalon slave, word addressed
    input  wire logic [2:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // trigger sources, bit 0 unused
    input  wire logic [7:0]  trig_in,
    // interrupt line and vector service
    output logic             conv_irq,
    input  wire logic        irq_ack,
    // analog core side
    input  wire logic [9:0]  core_result,
    output logic             core_enable,
    output logic             core_sample,
    output logic      [5:0]  core_channel,
    output logic      [1:0]  core_reference,
    output logic             core_amp_bypass
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        acc_phase_type ph;        // idle or converting
        logic          en;        // converter_enable
        logic          pend;      // start waiting for tick
        logic          auto_en;   // auto_trigger_enable
        logic          flag;      // conversion_complete_flag
        logic          ie;        // interrupt enable
        logic [2:0]    ps;        // prescaler_select
        logic [2:0]    tsel;      // trigger_select
        logic          mux5;      // channel_select bit 5
        logic [1:0]    refs;      // reference_select
        logic          ladj;      // left_adjust
        logic [4:0]    channel_select;       // channel_select low bits
        logic          pwr;       // converter_power_reduction
        logic          lock;      // data bytes blocked
        logic [9:0]    res;       // stored result
        logic [5:0]    act_ch;    // channel given to the core
        logic [1:0]    act_ref;   // reference given to the core
        logic [4:0]    cnt;       // ticks left in conversion
        logic          first;     // next conversion is the long one
        logic          trig_prev; // trigger level last cycle
        logic          ack;       // bus answer cycle
        logic [7:0]    rdata;     // read data
        logic          sample;    // sample pulse to the core
        logic [9:0]    smp_meta;  // result sync stage one
        logic [9:0]    smp_sync;  // result sync stage two
    } acc_state_type;

    acc_state_type s_r;      // registered state
    acc_state_type s_nxt;    // next state
    logic          req;      // bus request present
    logic          take;     // request completes this edge
    logic          eff_en;   // enabled and powered
    logic          trig_now; // selected trigger level
    logic          trig_go;  // accepted trigger edge
    logic          free_run; // own flag as trigger
    logic          done;     // conversion completes this edge
    logic [4:0]    load;     // tick count of a new conversion
    logic [7:0]    ctrl_a_view; // control word as software reads it

    acc_pre_if     pif ();   // prescaler link

    // single ended codes bypass the gain stage
    function automatic logic single_ended(input logic [5:0] ch);
        return (ch[4:3] == 2'h0) || (ch == CH_BANDGAP) || (ch == CH_GROUND);
    endfunction

    // register read value, alignment applied on the way out
    function automatic logic [7:0] rd_val(input logic [2:0] a,
                                          input acc_state_type s);
        logic [7:0] v;
        v = 8'h00;
        case (a)
            IDX_RES_LO: v = s.ladj ? {s.res[1:0], 6'h00} : s.res[7:0];
            IDX_RES_HI: v = s.ladj ? s.res[9:2] : {6'h00, s.res[9:8]};
            IDX_CTRL_A: v = {s.en, (s.pend | (s.ph == ACC_RUN)), s.auto_en,
                             s.flag, s.ie, s.ps};
            IDX_CTRL_B: v = {4'h0, s.mux5, s.tsel};
            IDX_INSEL:  v = {s.refs, s.ladj, s.channel_select};
            IDX_PWR:    v = {7'h00, s.pwr};
            default:    v = 8'h00; // unmapped reads zero
        endcase
        return v;
    endfunction

    // ----------------------------------------
    // prescaler
    // ----------------------------------------
    assign pif.run     = eff_en;
    assign pif.restart = trig_go;
    assign pif.sel     = s_r.ps;

    acc_prescaler u_pre (
        .sys_clk (sys_clk),
        .reset_n (reset_n),
        .pif     (pif)
    );

    // ----------------------------------------
    // decode of bus and events
    // ----------------------------------------
    // one wait cycle per access keeps read data registered
    assign req      = avs_read | avs_write;
    assign take     = req & s_r.ack;
    assign eff_en   = s_r.en & ~s_r.pwr;
    assign free_run = s_r.auto_en & (s_r.tsel == TS_FREE);
    assign trig_now = (s_r.tsel == TS_FREE) ? 1'b0 : trig_in[s_r.tsel];
    // only a fresh edge on the selected input, in idle, fires a trigger
    assign trig_go  = eff_en & s_r.auto_en & (s_r.ph == ACC_IDLE)
                    & trig_now & ~s_r.trig_prev;
    assign done     = (s_r.ph == ACC_RUN) & pif.tick & (s_r.cnt == 5'h01);
    assign load     = s_r.first ? CONV_FIRST : CONV_NORMAL;

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb
    begin
        s_nxt           = s_r;
        s_nxt.ack       = req & ~s_r.ack;
        s_nxt.sample    = 1'b0;
        s_nxt.trig_prev = trig_now;
        s_nxt.smp_meta  = core_result;
        s_nxt.smp_sync  = s_r.smp_meta;
        if (req && !s_r.ack)
        begin
            s_nxt.rdata = rd_val(avs_address, s_r);
        end
        // vector service clears the flag; a same-cycle set wins below
        if (irq_ack)
        begin
            s_nxt.flag = 1'b0;
        end
        // register writes
        if (take && avs_write)
        begin
            case (avs_address)
                IDX_CTRL_A:
                begin
                    s_nxt.en      = avs_writedata[A_EN];
                    s_nxt.auto_en = avs_writedata[A_AUTO];
                    s_nxt.ie      = avs_writedata[A_IE];
                    s_nxt.ps      = avs_writedata[2:0];
                    if (avs_writedata[A_FLAG])
                    begin
                        s_nxt.flag = 1'b0;
                    end
                    // start held until the next converter tick
                    if (avs_writedata[A_START] && avs_writedata[A_EN]
                        && !s_r.pwr && s_r.ph == ACC_IDLE)
                    begin
                        s_nxt.pend = 1'b1;
                    end
                    if (!avs_writedata[A_EN])
                    begin
                        s_nxt.pend = 1'b0;
                    end
                end
                IDX_CTRL_B:
                begin
                    s_nxt.mux5 = avs_writedata[B_MUX5];
                    s_nxt.tsel = avs_writedata[2:0];
                end
                IDX_INSEL:
                begin
                    s_nxt.refs = avs_writedata[I_REF +: 2];
                    s_nxt.ladj = avs_writedata[I_LADJ];
                    s_nxt.channel_select  = avs_writedata[4:0];
                end
                IDX_PWR:
                begin
                    s_nxt.pwr = avs_writedata[P_PRED];
                end
                default:
                begin
                    s_nxt.pwr = s_nxt.pwr; // unmapped writes ignored
                end
            endcase
        end
        // result byte reads drive the lock
        if (take && avs_read && avs_address == IDX_RES_LO)
        begin
            s_nxt.lock = 1'b1;
        end
        if (take && avs_read && avs_address == IDX_RES_HI)
        begin
            s_nxt.lock = 1'b0;
        end
        // selections follow the registers only while enabled, when idle or on the completing edge
        if (eff_en && (s_r.ph == ACC_IDLE || done))
        begin
            s_nxt.act_ch  = {s_r.mux5, s_r.channel_select};
            s_nxt.act_ref = s_r.refs;
        end
        // conversion sequencer
        if (!eff_en)
        begin
            s_nxt.ph    = ACC_IDLE;
            // a start written together with enable survives
            s_nxt.pend  = s_nxt.pend & s_nxt.en & ~s_nxt.pwr;
            s_nxt.cnt   = 5'h00;
            s_nxt.first = 1'b1; // next enable pays the long start
        end
        else if (s_r.ph == ACC_IDLE)
        begin
            if (trig_go || (s_r.pend && pif.tick))
            begin
                s_nxt.ph     = ACC_RUN;
                s_nxt.pend   = 1'b0;
                s_nxt.cnt    = load;
                s_nxt.first  = 1'b0;
                s_nxt.sample = 1'b1;
            end
        end
        else if (pif.tick)
        begin
            s_nxt.cnt = s_r.cnt - 5'h01;
            if (done)
            begin
                // lost result still raises the flag
                s_nxt.flag = 1'b1;
                // a low byte read in flight also blocks, or the pair splits
                if (!s_r.lock && !(avs_read && avs_address == IDX_RES_LO))
                begin
                    s_nxt.res = s_r.smp_sync;
                end
                if (free_run)
                begin
                    s_nxt.cnt    = CONV_NORMAL;
                    s_nxt.sample = 1'b1;
                end
                else
                begin
                    s_nxt.ph = ACC_IDLE;
                end
            end
        end
    end

    // state register
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            s_r     <= '0;
            s_r.pwr <= PWR_RST;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign avs_readdata    = {24'h000000, s_r.rdata};
    assign avs_waitrequest = req & ~s_r.ack;
    assign conv_irq        = s_r.flag & s_r.ie;
    assign core_enable     = eff_en;
    assign core_sample     = s_r.sample;
    assign core_channel    = s_r.act_ch;
    assign core_reference  = s_r.act_ref;
    assign core_amp_bypass = single_ended(s_r.act_ch);

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    assign ctrl_a_view = rd_val(IDX_CTRL_A, s_r);

    sequence s_finish;
        done;
    endsequence
    sequence s_low_read;
        take && avs_read && avs_address == IDX_RES_LO;
    endsequence

    lock_keeps_a: assert property ((s_finish and s_r.lock) |=> $stable(s_r.res))
        else $error("locked result changed");
    low_then_hi_a: assert property (s_low_read ##1 !take[*2] |-> s_r.lock)
        else $error("lock not set by low byte read");
    hi_unlock_a: assert property (take && avs_read && avs_address == IDX_RES_HI
        && !done |=> !s_r.lock)
        else $error("high byte read left the lock on");
    lost_flag_a: assert property (s_finish |=> s_r.flag)
        else $error("flag missing after completion");
    start_reads_a: assert property (s_r.ph == ACC_RUN |->
        ctrl_a_view[A_START])
        else $error("start bit low during conversion");
    sel_frozen_a: assert property (s_r.ph == ACC_RUN && !done
        |=> $stable(s_r.act_ch) && $stable(s_r.act_ref))
        else $error("channel moved mid conversion");
    off_no_apply_a: assert property (!eff_en |=> $stable(s_r.act_ch))
        else $error("selection applied while disabled");
    long_first_a: assert property (eff_en && s_r.ph == ACC_IDLE && s_r.first
        && (trig_go || (s_r.pend && pif.tick)) |=> s_r.cnt == CONV_FIRST)
        else $error("first conversion not 25 ticks");
    edge_ignored_a: assert property (s_r.ph == ACC_RUN && !done && eff_en
        |=> s_r.ph == ACC_RUN)
        else $error("conversion cut short");
    single_end_a: assert property ((s_finish and !free_run) |=>
        s_r.ph == ACC_IDLE && !ctrl_a_view[A_START])
        else $error("single conversion did not stop");
    free_go_a: assert property ((s_finish and (free_run && eff_en)) |=>
        s_r.ph == ACC_RUN && s_r.cnt == CONV_NORMAL)
        else $error("free running did not restart");
endmodule

// *** logic/acc_pkg.sv ***
// constants for the converter control block
package acc_pkg;
    // ----------------------------------------
    // register word indices
    // ----------------------------------------
    localparam logic [2:0] IDX_RES_LO = 3'h0; // result low byte
    localparam logic [2:0] IDX_RES_HI = 3'h1; // result high byte
    localparam logic [2:0] IDX_CTRL_A = 3'h2; // converter_ctrl_a
    localparam logic [2:0] IDX_CTRL_B = 3'h3; // converter_ctrl_b
    localparam logic [2:0] IDX_INSEL  = 3'h4; // input_select_reg
    localparam logic [2:0] IDX_PWR    = 3'h5; // power_reduction_reg0
    // ----------------------------------------
    // field positions
    // ----------------------------------------
    localparam int A_EN    = 7; // converter_enable
    localparam int A_START = 6; // start_conversion
    localparam int A_AUTO  = 5; // auto_trigger_enable
    localparam int A_FLAG  = 4; // conversion_complete_flag
    localparam int A_IE    = 3; // interrupt enable
    localparam int B_MUX5  = 3; // channel_select bit 5
    localparam int I_REF   = 6; // reference_select lsb
    localparam int I_LADJ  = 5; // left_adjust
    localparam int P_PRED  = 0; // converter_power_reduction
    // ----------------------------------------
    // reset values and timing counts
    // ----------------------------------------
    localparam logic       PWR_RST     = 1'h0; // power reduction off
    localparam logic [4:0] CONV_NORMAL = 5'h0d; // 13 converter ticks
    localparam logic [4:0] CONV_FIRST  = 5'h19; // 25 converter ticks
    localparam logic [2:0] TS_FREE     = 3'h0; // own flag as trigger
    localparam logic [5:0] CH_BANDGAP  = 6'h1e; // fixed bandgap input
    localparam logic [5:0] CH_GROUND   = 6'h1f; // ground input
    // ----------------------------------------
    // conversion phases
    // ----------------------------------------
    typedef enum logic {ACC_IDLE, ACC_RUN} acc_phase_type;
endpackage

// *** logic/acc_pre_if.sv ***
// interface between control core and converter prescaler
`timescale 1ns/1ps
interface acc_pre_if;
    logic       run;     // converter enabled
    logic       restart; // trigger reset of the divider
    logic [2:0] sel;     // prescaler_select
    logic       tick;    // one converter clock step
    modport ctrl (output run, output restart, output sel, input tick);
    modport pre  (input run, input restart, input sel, output tick);
endinterface

// *** logic/acc_prescaler.sv ***
// converter clock prescaler, emits one tick per divided period
`timescale 1ns/1ps
module acc_prescaler
    import acc_pkg::*;
(
    // clock and reset
    input  wire logic sys_clk,
    input  wire logic reset_n,
    // control side
    acc_pre_if.pre    pif
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        logic [6:0] cnt; // divider count
    } acc_pre_type;
    acc_pre_type s_r;   // registered state
    acc_pre_type s_nxt; // next state
    logic [6:0]  term;  // last count of a period

    // divisor is two to the select, select zero also halves
    function automatic logic [6:0] last_count(input logic [2:0] sel);
        logic [7:0] div;
        div = 8'h01 << ((sel == 3'h0) ? 3'h1 : sel);
        return 7'(div - 8'h01);
    endfunction

    // ----------------------------------------
    // divider
    // ----------------------------------------
    assign term     = last_count(pif.sel);
    assign pif.tick = pif.run & ~pif.restart & (s_r.cnt == term);

    // held at zero while disabled, restarted by a trigger
    always_comb
    begin
        s_nxt = s_r;
        if (!pif.run || pif.restart || pif.tick)
        begin
            s_nxt.cnt = 7'h00;
        end
        else
        begin
            s_nxt.cnt = s_r.cnt + 7'h01;
        end
    end

    // state register
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            s_r <= '0;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    hold_zero_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        !pif.run |=> s_r.cnt == 7'h00)
        else $error("prescaler counted while disabled");
    tick_gap_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        pif.tick && pif.run && !pif.restart ##1 pif.run && !pif.restart |-> !pif.tick)
        else $error("prescaler ticked on two cycles in a row");
endmodule

// *** verification/acc_top_tb.sv ***
// self-checking bench for the converter control block
`timescale 1ns/1ps
module acc_top_tb
    import acc_pkg::*;
;
    // ----------------------------------------
    // signals and bookkeeping
    // ----------------------------------------
    typedef struct packed {logic [2:0] a; logic [7:0] w; logic [7:0] e;} acc_row_type;
    logic        sys_clk;       // 125 MHz clock
    logic        reset_n;       // synchronous, active low
    logic [2:0]  avs_address;   // word index
    logic        avs_read;      // read request
    logic        avs_write;     // write request
    logic [31:0] avs_writedata; // write data
    logic [31:0] avs_readdata;  // read data
    logic        avs_waitrequest; // slave stall
    logic [7:0]  trig_in;       // trigger sources
    logic        conv_irq;      // completion interrupt
    logic        irq_ack;       // vector service pulse
    logic [9:0]  core_result;   // analog result
    logic        core_enable;   // core power
    logic        core_sample;   // conversion start pulse
    logic [5:0]  core_channel;  // applied channel
    logic [1:0]  core_reference; // applied reference
    logic        core_amp_bypass; // gain stage bypass
    int          err_total;     // mismatches seen
    int          n_compared;    // comparisons made
    int          n_samp;        // conversion starts seen
    int          cyc;           // free cycle count
    int          samp_at;       // cycle of last start
    int          s0;            // start count snapshot
    logic [31:0] rd;            // scratch read data
    // register rows: written value beside the read-back it should give
    acc_row_type rows [0:8] = '{
        '{IDX_CTRL_B, 8'h0b, 8'h0b}, '{IDX_INSEL, 8'hc5, 8'hc5}, '{IDX_PWR, 8'h01, 8'h01},
        '{IDX_PWR, 8'h00, 8'h00}, '{3'h6, 8'h55, 8'h00}, '{3'h7, 8'haa, 8'h00},
        '{IDX_CTRL_A, 8'h07, 8'h07}, '{IDX_INSEL, 8'h00, 8'h00}, '{IDX_CTRL_B, 8'h00, 8'h00}};

    acc_top uut (
        .sys_clk(sys_clk), .reset_n(reset_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .trig_in(trig_in), .conv_irq(conv_irq), .irq_ack(irq_ack),
        .core_result(core_result), .core_enable(core_enable), .core_sample(core_sample),
        .core_channel(core_channel), .core_reference(core_reference),
        .core_amp_bypass(core_amp_bypass));

    // clock, free cycle count and start-pulse counter
    initial
    begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk)
    begin
        cyc <= cyc + 1;
        if (core_sample === 1'b1)
        begin
            n_samp  <= n_samp + 1;
            samp_at <= cyc;
        end
    end

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic end_sim();
        if (err_total == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            err_total++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic hang(input string what);
        err_total++;
        $display("MISMATCH t=%0t timeout %s", $time, what);
        end_sim();
    endtask
    // one avalon access; request held until waitrequest seen low
    task automatic bus(input logic wr, input logic [2:0] adr, input logic [7:0] wd,
                       output logic [31:0] data);
        int k;
        @(posedge sys_clk);
        avs_address   <= adr;
        avs_writedata <= {24'h0, wd};
        avs_write     <= wr;
        avs_read      <= ~wr;
        k = 0;
        do
        begin
            @(posedge sys_clk);
            k++;
        end
        while (avs_waitrequest !== 1'b0 && k < 20);
        if (k >= 20)
            hang("bus");
        data = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic wr(input logic [2:0] adr, input logic [7:0] wd);
        bus(1'b1, adr, wd, rd);
    endtask
    task automatic rdchk(input logic [2:0] adr, input logic [7:0] exp);
        bus(1'b0, adr, 8'h00, rd);
        chk(rd, {24'h0, exp});
    endtask
    // wait for the interrupt; positive ticks also checks conversion length against ticks*div
    task automatic wait_irq(input int ticks, input int div);
        int k;
        k = 0;
        while (conv_irq !== 1'b1 && k < 400)
        begin
            @(negedge sys_clk);
            k++;
        end
        if (k >= 400)
            hang("irq");
        if (ticks > 0)
            chk(32'((cyc - samp_at) >= ticks * div - 3 && (cyc - samp_at) <= ticks * div + 3), 1);
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        {avs_address, avs_read, avs_write, avs_writedata, trig_in, irq_ack} = '0;
        {err_total, n_compared, n_samp, cyc, samp_at} = '0;
        core_result = 10'h2b5;
        reset_n = 1'b0;
        repeat (6) @(posedge sys_clk);
        reset_n <= 1'b1;
        // ordinary register rows, unmapped indices read zero
        foreach (rows[i])
        begin
            wr(rows[i].a, rows[i].w);
            rdchk(rows[i].a, rows[i].e);
        end
        // selection held back while disabled, applied once enabled
        wr(IDX_INSEL, 8'h45);
        @(negedge sys_clk);
        chk(32'(core_channel), 32'h0);
        // start refused while powered down, then converter switched off
        wr(IDX_PWR, 8'h01);
        wr(IDX_CTRL_A, 8'hc8);
        rdchk(IDX_CTRL_A, 8'h88);
        chk(32'(core_enable), 32'h0);
        wr(IDX_CTRL_A, 8'h08);
        chk(32'(core_enable), 32'h0);
        wr(IDX_PWR, 8'h00);
        wr(IDX_CTRL_A, 8'hc8);
        rdchk(IDX_CTRL_A, 8'hc8);
        chk({29'h0, core_reference, core_amp_bypass}, 32'h3);
        chk(32'(core_channel), 32'h5);
        wait_irq(25, 2);
        rdchk(IDX_CTRL_A, 8'h98);
        rdchk(IDX_RES_LO, 8'hb5);
        rdchk(IDX_RES_HI, 8'h02);
        wr(IDX_CTRL_A, 8'h9a);
        @(negedge sys_clk);
        chk(32'(conv_irq), 32'h0);
        // normal length at the slower divider, then left alignment
        wr(IDX_CTRL_A, 8'hca);
        wait_irq(13, 4);
        wr(IDX_INSEL, 8'h65);
        rdchk(IDX_RES_HI, 8'had);
        rdchk(IDX_RES_LO, 8'h40);
        rdchk(IDX_RES_HI, 8'had);
        @(posedge sys_clk);
        irq_ack <= 1'b1;
        @(posedge sys_clk);
        irq_ack <= 1'b0;
        @(negedge sys_clk);
        chk(32'(conv_irq), 32'h0);
        // ----------------------------------------
        // awkward cases: result lock, channel change mid-conversion
        // ----------------------------------------
        wr(IDX_INSEL, 8'h45);
        rdchk(IDX_RES_LO, 8'hb5);
        core_result <= 10'h155;
        wr(IDX_CTRL_A, 8'hda);
        wait_irq(0, 0);
        rdchk(IDX_RES_HI, 8'h02);
        wr(IDX_CTRL_A, 8'hda);
        repeat (8) @(posedge sys_clk);
        rdchk(IDX_CTRL_A, 8'hca);
        wr(IDX_INSEL, 8'h47);
        @(negedge sys_clk);
        chk(32'(core_channel), 32'h5);
        wait_irq(0, 0);
        repeat (3) @(negedge sys_clk);
        chk(32'(core_channel), 32'h7);
        rdchk(IDX_RES_LO, 8'h55);
        rdchk(IDX_RES_HI, 8'h01);
        // auto trigger: one edge starts, mid-conversion edge and held level do not
        wr(IDX_CTRL_B, 8'h02);
        wr(IDX_CTRL_A, 8'hb8);
        s0 = n_samp;
        @(posedge sys_clk);
        trig_in <= 8'h04;
        repeat (4) @(negedge sys_clk);
        chk(32'(n_samp - s0), 32'h1);
        rdchk(IDX_CTRL_A, 8'he8);
        trig_in <= 8'h00;
        @(posedge sys_clk);
        trig_in <= 8'h04;
        wait_irq(0, 0);
        repeat (40) @(negedge sys_clk);
        chk(32'(n_samp - s0), 32'h1);
        // own flag as trigger: free running after one software start
        wr(IDX_CTRL_B, 8'h00);
        wr(IDX_CTRL_A, 8'he8);
        s0 = n_samp;
        repeat (100) @(negedge sys_clk);
        chk(32'(n_samp - s0 >= 3), 32'h1);
        rdchk(IDX_CTRL_A, 8'hf8);
        // reset in mid-run clears registers, interrupt, core enable and channel
        @(posedge sys_clk);
        reset_n <= 1'b0;
        repeat (2) @(negedge sys_clk);
        chk({22'h0, conv_irq, core_enable, core_channel, core_amp_bypass}, 32'h1);
        @(posedge sys_clk);
        reset_n <= 1'b1;
        rdchk(IDX_CTRL_A, 8'h00);
        rdchk(IDX_PWR, 8'h00);
        end_sim();
    end
endmodule
